// ---- mcyc_pkg.sv ----
// package of timing constants for the machine-cycle sequencer
`default_nettype none
package mcyc_pkg;
    localparam int unsigned CLK_PER_MCYC = 4;
    localparam int unsigned TMR_SLOW_CLKS = 12;
    localparam int unsigned TMR_FAST_CLKS = 4;
    localparam int unsigned MAX_MCYC = 5;
    localparam int unsigned XDATA_MIN_MCYC = 2;
    localparam int unsigned XDATA_MAX_MCYC = 9;
    localparam int unsigned NUM_TIMERS = 3;
    localparam logic [2:0] CLKCTL_RESET = 3'h0;
    localparam logic [2:0] STRETCH_RESET = 3'h1;
    // opcodes for the cycle lookup; external move lengths follow the stretch code
    localparam logic [7:0] OP_XDATA_RD_DP = 8'h_e0;
    localparam logic [7:0] OP_XDATA_RD_RI0 = 8'h_e2;
    localparam logic [7:0] OP_XDATA_RD_RI1 = 8'h_e3;
    localparam logic [7:0] OP_XDATA_WR_DP = 8'h_f0;
    localparam logic [7:0] OP_XDATA_WR_RI0 = 8'h_f2;
    localparam logic [7:0] OP_XDATA_WR_RI1 = 8'h_f3;
    localparam logic [7:0] OP_MOV_DIR_DIR = 8'h_85;
    localparam logic [7:0] OP_MOV_DIR_IMM = 8'h_75;
    localparam logic [7:0] OP_MOV_DP_IMM = 8'h_90;
    localparam logic [7:0] OP_MUL = 8'h_a4;
    localparam logic [7:0] OP_DIV = 8'h_84;
    localparam logic [7:0] OP_UNUSED = 8'h_a5;
    localparam logic [7:0] OP_MOV_DIR_RN_LO = 8'h_88;
    localparam logic [7:0] OP_MOV_RI_DIR_LO = 8'h_a6;
    localparam logic [7:0] OP_MOV_RI_IMM_LO = 8'h_76;
    localparam logic [7:0] OP_IMM_COL = 8'h_04;
    localparam logic [7:0] OP_DIR_COL = 8'h_05;
    localparam logic [2:0] ONE_MCYC = 3'h1;
    localparam logic [2:0] TWO_MCYC = 3'h2;
    localparam logic [2:0] THREE_MCYC = 3'h3;
    localparam logic [2:0] FIVE_MCYC = 3'h5;
    typedef enum logic [1:0] {MCYC_FETCH, MCYC_EXEC, MCYC_XDATA} mcyc_state_t;
endpackage
`default_nettype wire

// ---- mcyc_seq.sv ----
// machine-cycle sequencer, opcode cycle lookup and timer prescalers
`default_nettype none

module mcyc_seq #(
    parameter int unsigned NUM_TIMERS = mcyc_pkg::NUM_TIMERS
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] opcode,
    input wire logic [NUM_TIMERS-1:0] clock_control_reg,
    input wire logic [2:0] xdata_stretch,
    output logic addr_latch_strobe,
    output logic fetch_strobe,
    output logic instr_done,
    output logic xdata_active,
    output logic bad_opcode,
    output logic [3:0] instr_mcyc,
    output logic [NUM_TIMERS-1:0] timer_tick
);
    localparam int unsigned PH_W = $clog2(mcyc_pkg::CLK_PER_MCYC);
    localparam logic [PH_W-1:0] PH_LAST = PH_W'(mcyc_pkg::CLK_PER_MCYC - 1);
    localparam logic [3:0] PRE_SLOW_LAST = 4'(mcyc_pkg::TMR_SLOW_CLKS - 1);
    localparam logic [3:0] PRE_FAST_LAST = 4'(mcyc_pkg::TMR_FAST_CLKS - 1);

    // ==========================================================
    // clock phase within machine cycle
    logic [PH_W-1:0] phase_ff;
    logic mcyc_end;
    assign mcyc_end = (phase_ff == PH_LAST);

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            phase_ff <= '0;
        end else begin
            phase_ff <= mcyc_end ? '0 : phase_ff + 1'b1;
        end
    end

    // strobe in the first clock of each cycle
    assign addr_latch_strobe = (phase_ff == '0);

    // ==========================================================
    // opcode cycle lookup
    // only the cycle count is produced here; data effects belong to the datapath
    function automatic logic [2:0] op_mcyc(input logic [7:0] op);
        logic [2:0] n;
        n = mcyc_pkg::ONE_MCYC;
        // column 4 immediate and 5 direct forms carry an operand byte
        if (op[7:4] >= 4'h2 && (op[3:0] == mcyc_pkg::OP_IMM_COL[3:0]
                || op[3:0] == mcyc_pkg::OP_DIR_COL[3:0])) begin
            n = mcyc_pkg::TWO_MCYC;
        end
        if ((op & 8'h_f8) == mcyc_pkg::OP_MOV_DIR_RN_LO ||
            (op & 8'h_fe) == mcyc_pkg::OP_MOV_RI_DIR_LO ||
            (op & 8'h_fe) == mcyc_pkg::OP_MOV_RI_IMM_LO) begin
            n = mcyc_pkg::TWO_MCYC;
        end
        if (op == mcyc_pkg::OP_MOV_DIR_DIR) begin
            n = mcyc_pkg::THREE_MCYC;
        end
        if (op == mcyc_pkg::OP_MOV_DIR_IMM) begin
            n = mcyc_pkg::THREE_MCYC;
        end
        if (op == mcyc_pkg::OP_MOV_DP_IMM) begin
            n = mcyc_pkg::THREE_MCYC;
        end
        if (op == mcyc_pkg::OP_MUL || op == mcyc_pkg::OP_DIV) begin
            n = mcyc_pkg::FIVE_MCYC;
        end
        return n;
    endfunction

    logic is_xdata;
    assign is_xdata = (opcode == mcyc_pkg::OP_XDATA_RD_DP) ||
                      (opcode == mcyc_pkg::OP_XDATA_RD_RI0) ||
                      (opcode == mcyc_pkg::OP_XDATA_RD_RI1) ||
                      (opcode == mcyc_pkg::OP_XDATA_WR_DP) ||
                      (opcode == mcyc_pkg::OP_XDATA_WR_RI0) ||
                      (opcode == mcyc_pkg::OP_XDATA_WR_RI1);

    // stretch code 0 gives two cycles, code 7 gives nine
    logic [3:0] xdata_len;
    assign xdata_len = 4'(xdata_stretch) + 4'(mcyc_pkg::XDATA_MIN_MCYC);

    logic [3:0] lookup_len;
    assign lookup_len = is_xdata ? xdata_len : {1'b0, op_mcyc(opcode)};

    // ==========================================================
    // sequencer
    mcyc_pkg::mcyc_state_t state_ff;
    logic [3:0] remain_ff;
    logic [3:0] len_ff;
    logic bad_ff;

    assign fetch_strobe = (state_ff == mcyc_pkg::MCYC_FETCH) && mcyc_end;
    assign instr_done = (state_ff != mcyc_pkg::MCYC_FETCH) && mcyc_end && (remain_ff == 4'h1);
    assign xdata_active = (state_ff == mcyc_pkg::MCYC_XDATA);
    assign instr_mcyc = len_ff;
    assign bad_opcode = bad_ff;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= mcyc_pkg::MCYC_FETCH;
            remain_ff <= 4'h0;
            len_ff <= 4'h0;
            bad_ff <= 1'b0;
        end else if (mcyc_end) begin
            unique case (state_ff)
                mcyc_pkg::MCYC_FETCH: begin
                    // fetch cycle counts as the first of the instruction
                    len_ff <= lookup_len;
                    bad_ff <= (opcode == mcyc_pkg::OP_UNUSED);
                    if (lookup_len == 4'h1) begin
                        state_ff <= mcyc_pkg::MCYC_FETCH;
                    end else begin
                        remain_ff <= lookup_len - 4'h1;
                        state_ff <= is_xdata ? mcyc_pkg::MCYC_XDATA : mcyc_pkg::MCYC_EXEC;
                    end
                end
                mcyc_pkg::MCYC_EXEC, mcyc_pkg::MCYC_XDATA: begin
                    remain_ff <= remain_ff - 4'h1;
                    if (remain_ff == 4'h1) begin
                        state_ff <= mcyc_pkg::MCYC_FETCH;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // timer prescalers, one per timer
    genvar gi;
    generate
        for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_tmr
            logic [3:0] pre_ff;
            logic [3:0] pre_last;
            logic [3:0] gap_ff;
            logic rate_ref_ff;
            logic rate_same_ff;
            // rate bit low after reset keeps legacy twelve-clock ticks
            assign pre_last = clock_control_reg[gi] ? PRE_FAST_LAST : PRE_SLOW_LAST;
            always_ff @(posedge clk_sys or negedge reset_n) begin
                if (!reset_n) begin
                    pre_ff <= 4'h0;
                end else if (pre_ff >= pre_last) begin
                    pre_ff <= 4'h0;
                end else begin
                    pre_ff <= pre_ff + 4'h1;
                end
            end
            assign timer_tick[gi] = (pre_ff >= pre_last);

            // ======================================================
            // tick spacing watch, kept apart from the prescaler itself
            // clocks since the previous tick, saturating so it never wraps
            always_ff @(posedge clk_sys or negedge reset_n) begin
                if (!reset_n) begin
                    gap_ff <= 4'h0;
                end else if (timer_tick[gi]) begin
                    gap_ff <= 4'h0;
                end else if (gap_ff != 4'hf) begin
                    gap_ff <= gap_ff + 4'h1;
                end
            end

            // rate seen at the last tick and whether it has held since
            always_ff @(posedge clk_sys or negedge reset_n) begin
                if (!reset_n) begin
                    rate_ref_ff <= 1'b0;
                    rate_same_ff <= 1'b0;
                end else if (timer_tick[gi]) begin
                    rate_ref_ff <= clock_control_reg[gi];
                    rate_same_ff <= 1'b1;
                end else if (clock_control_reg[gi] != rate_ref_ff) begin
                    rate_same_ff <= 1'b0;
                end
            end

            // a rate change mid-period is exempt, as its first gap is mixed
            a_slow_tick: assert property (@(posedge clk_sys) disable iff (!reset_n)
                timer_tick[gi] && rate_same_ff && !rate_ref_ff
                    && clock_control_reg[gi] == rate_ref_ff
                    |-> gap_ff == PRE_SLOW_LAST)
                else $error("slow timer rate wrong");
            a_fast_tick: assert property (@(posedge clk_sys) disable iff (!reset_n)
                timer_tick[gi] && rate_same_ff && rate_ref_ff
                    && clock_control_reg[gi] == rate_ref_ff
                    |-> gap_ff == PRE_FAST_LAST)
                else $error("fast timer rate wrong");
            a_tick_pulse: assert property (@(posedge clk_sys) disable iff (!reset_n)
                timer_tick[gi] |=> !timer_tick[gi])
                else $error("timer tick longer than one clock");
        end
    endgenerate

    // ==========================================================
    // checks
    a_mcyc_period: assert property (@(posedge clk_sys) disable iff (!reset_n)
        addr_latch_strobe |=> !addr_latch_strobe [*3] ##1 addr_latch_strobe)
        else $error("machine cycle not four clocks");
    a_one_strobe: assert property (@(posedge clk_sys) disable iff (!reset_n)
        mcyc_end |-> ##1 addr_latch_strobe)
        else $error("missing latch strobe");
    sequence s_fetch_long(int n);
        fetch_strobe && opcode == mcyc_pkg::OP_MOV_DIR_DIR;
    endsequence
    a_dir_dir_len: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_fetch_long(0) |-> ##8 instr_done)
        else $error("direct move not three cycles");
    a_imm_dir_len: assert property (@(posedge clk_sys) disable iff (!reset_n)
        fetch_strobe && opcode == mcyc_pkg::OP_MOV_DIR_IMM |-> ##8 instr_done)
        else $error("immediate store not twelve clocks");
    a_dp_load_len: assert property (@(posedge clk_sys) disable iff (!reset_n)
        fetch_strobe && opcode == mcyc_pkg::OP_MOV_DP_IMM |-> ##8 instr_done)
        else $error("pointer load not twelve clocks");
    a_xdata_min: assert property (@(posedge clk_sys) disable iff (!reset_n)
        fetch_strobe && is_xdata && xdata_stretch == 3'h0 |-> ##4 instr_done)
        else $error("external move not two cycles");
    a_len_bound: assert property (@(posedge clk_sys) disable iff (!reset_n)
        state_ff == mcyc_pkg::MCYC_EXEC |-> len_ff <= 4'(mcyc_pkg::MAX_MCYC))
        else $error("instruction beyond five cycles");
    a_xdata_range: assert property (@(posedge clk_sys) disable iff (!reset_n)
        xdata_active |-> len_ff >= 4'(mcyc_pkg::XDATA_MIN_MCYC)
            && len_ff <= 4'(mcyc_pkg::XDATA_MAX_MCYC))
        else $error("stretch out of range");
    a_one_byte_fetch: assert property (@(posedge clk_sys) disable iff (!reset_n)
        fetch_strobe && lookup_len == 4'h1 |-> ##4 fetch_strobe)
        else $error("one-byte op not one cycle");

    // completion is followed by a fetch one machine cycle later, never earlier
    sequence s_next_fetch;
        !fetch_strobe [*3] ##1 fetch_strobe;
    endsequence
    a_done_then_fetch: assert property (@(posedge clk_sys) disable iff (!reset_n)
        instr_done |=> s_next_fetch)
        else $error("next fetch not one cycle after done");
    a_mul_div_len: assert property (@(posedge clk_sys) disable iff (!reset_n)
        fetch_strobe && (opcode == mcyc_pkg::OP_MUL || opcode == mcyc_pkg::OP_DIV)
            |-> ##16 instr_done)
        else $error("multiply or divide not five cycles");
    a_xdata_max: assert property (@(posedge clk_sys) disable iff (!reset_n)
        fetch_strobe && is_xdata && xdata_stretch == 3'h7 |-> ##32 instr_done)
        else $error("longest external move not nine cycles");
    a_xdata_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
        fetch_strobe && is_xdata |=> xdata_active [*4])
        else $error("external move flag missing");
    a_bad_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
        fetch_strobe && opcode == mcyc_pkg::OP_UNUSED |=> bad_opcode)
        else $error("unused opcode not flagged");
    a_one_cycle_quiet: assert property (@(posedge clk_sys) disable iff (!reset_n)
        fetch_strobe && lookup_len == 4'h1 |=> !instr_done [*4])
        else $error("one-cycle op raised done");
    a_remain_cap: assert property (@(posedge clk_sys) disable iff (!reset_n)
        state_ff == mcyc_pkg::MCYC_EXEC |-> remain_ff < 4'(mcyc_pkg::MAX_MCYC))
        else $error("remaining count beyond five cycles");
endmodule
`default_nettype wire

// ---- mcyc_prog_mem.sv ----
// program memory model that answers opcode fetches of the sequencer
`default_nettype none
module mcyc_prog_mem (
    input wire logic fetch_strobe,
    input wire logic [7:0] prog_op,
    output logic [7:0] opcode
);
    timeunit 1ns;
    timeprecision 1ps;
    // outside a fetch the bus shows junk, so a late sample is caught
    assign opcode = fetch_strobe ? prog_op : ~prog_op;
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the machine-cycle sequencer
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] op; logic [2:0] st; int n; logic bad;} mcyc_row_t;
    logic clk_sys, reset_n, addr_latch_strobe, fetch_strobe, instr_done, xdata_active, bad_opcode;
    logic [7:0] prog_op, opcode;
    logic [2:0] clock_control_reg, xdata_stretch, timer_tick;
    logic [3:0] instr_mcyc;
    int num_errors = 0;
    int total_checks = 0;
    // n of 0: length not fixed, only the flag is checked
    mcyc_row_t rows[16] = '{'{8'h00, 0, 1, 0}, '{8'h24, 0, 2, 0}, '{8'h25, 0, 2, 0},
        '{8'h88, 0, 2, 0}, '{8'h85, 0, 3, 0}, '{8'h75, 0, 3, 0}, '{8'h90, 0, 3, 0},
        '{8'ha4, 0, 5, 0}, '{8'h84, 0, 5, 0}, '{8'he0, 0, 2, 0}, '{8'he2, 1, 3, 0},
        '{8'he3, 2, 4, 0}, '{8'hf0, 7, 9, 0}, '{8'hf2, 3, 5, 0}, '{8'hf3, 4, 6, 0},
        '{8'ha5, 0, 0, 1}};
    // ======================================================
    // design and memory model
    mcyc_seq mcyc_seq_inst (.clk_sys(clk_sys), .reset_n(reset_n), .opcode(opcode),
        .clock_control_reg(clock_control_reg), .xdata_stretch(xdata_stretch),
        .addr_latch_strobe(addr_latch_strobe), .fetch_strobe(fetch_strobe),
        .instr_done(instr_done), .xdata_active(xdata_active), .bad_opcode(bad_opcode),
        .instr_mcyc(instr_mcyc), .timer_tick(timer_tick));
    mcyc_prog_mem mcyc_prog_mem_inst (.fetch_strobe(fetch_strobe), .prog_op(prog_op),
        .opcode(opcode));
    // ======================================================
    // tasks
    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check_eq(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic wait_fetch;
        int k;
        k = 0;
        do begin
            @(negedge clk_sys);
            k++;
        end while (fetch_strobe !== 1'b1 && k < 100);
        check_eq("fetch seen", 16'h0001, {15'h0000, fetch_strobe});
    endtask
    // enters and leaves at the negedge of a fetch clock
    task automatic run_row(input mcyc_row_t r);
        int cyc, als, dn, xa;
        logic xe;
        xe = (r.op[7:4] == 4'he || r.op[7:4] == 4'hf)
            && (r.op[3:0] == 4'h0 || r.op[3:0] == 4'h2 || r.op[3:0] == 4'h3);
        @(posedge clk_sys);
        prog_op <= r.op;
        xdata_stretch <= r.st;
        wait_fetch();
        @(posedge clk_sys);
        prog_op <= 8'h00;
        cyc = 0;
        als = 0;
        dn = 0;
        xa = 0;
        do begin
            @(negedge clk_sys);
            cyc++;
            als += (addr_latch_strobe === 1'b1);
            dn += (instr_done === 1'b1);
            xa += (xdata_active === 1'b1);
        end while (fetch_strobe !== 1'b1 && cyc < 60);
        check_eq("bad flag", {15'h0000, r.bad}, {15'h0000, bad_opcode});
        if (r.n > 0) begin
            check_eq("clocks", 16'(4 * r.n), 16'(cyc));
            check_eq("strobes", 16'(r.n), 16'(als));
            check_eq("cycle count", 16'(r.n), {12'h000, instr_mcyc});
            check_eq("done pulses", 16'(r.n > 1), 16'(dn));
            check_eq("external move", 16'(xe ? 4 * (r.n - 1) : 0), 16'(xa));
        end
    endtask
    task automatic timer_rate(input logic [2:0] sel);
        int t[3];
        @(posedge clk_sys);
        clock_control_reg <= sel;
        // a new rate applies at once but its first gap is mixed, so let every prescaler wrap first
        repeat (24) @(posedge clk_sys);
        t = '{0, 0, 0};
        repeat (120) begin
            @(negedge clk_sys);
            for (int i = 0; i < 3; i++) t[i] += (timer_tick[i] === 1'b1);
        end
        for (int i = 0; i < 3; i++) begin
            check_eq("timer ticks", sel[i] ? 16'h001e : 16'h000a,
                16'(t[i]));
        end
    endtask
    // ======================================================
    // clock, watchdog, sequence
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        #80000;
        num_errors++;
        stop_test();
    end
    initial begin
        reset_n = 1'b0;
        prog_op = 8'h00;
        clock_control_reg = 3'h0;
        xdata_stretch = 3'h0;
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        timer_rate(3'h0);
        timer_rate(3'h5);
        timer_rate(3'h2);
        wait_fetch();
        foreach (rows[i]) run_row(rows[i]);
        run_row(rows[0]);
        // reset lands inside a five-cycle instruction
        run_row(rows[7]);
        @(posedge clk_sys);
        prog_op <= 8'ha4;
        wait_fetch();
        @(posedge clk_sys);
        prog_op <= 8'h00;
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b0;
        clock_control_reg <= 3'h0;
        @(negedge clk_sys);
        check_eq("reset outputs", 16'h8000, {addr_latch_strobe, fetch_strobe, instr_done,
            bad_opcode, instr_mcyc, xdata_active, 4'h0, timer_tick});
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        wait_fetch();
        run_row(rows[4]);
        timer_rate(3'h0);
        stop_test();
    end
endmodule
`default_nettype wire
